// ===== inc/flash_guard_pkg.sv
// Shared constants and types for the flash write and erase guard
package flash_guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special-function-register addresses seen by the core
  localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8F;  // Store control
  localparam logic [7:0] FLASH_LOCK_KEY_ADDR        = 8'hB6;  // Lock and key

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the store control register
  localparam int WRITE_ENABLE_BIT = 0;  // Program write enable
  localparam int ERASE_ENABLE_BIT = 1;  // Page erase enable

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key values, in order
  localparam logic [7:0] KEY_FIRST  = 8'hA5;  // First key
  localparam logic [7:0] KEY_SECOND = 8'hF1;  // Second key

  ////////////////////////////////////////////////////////////////////////////
  // Read-back padding and reset values
  localparam logic [5:0] UPPER_ZERO    = 6'h00;  // Bits 7:2 read as zero
  localparam logic [1:0] CONTROL_RESET = 2'h0;   // Both enables clear
  localparam logic [7:0] RDATA_RESET   = 8'h00;  // Read data after reset

  ////////////////////////////////////////////////////////////////////////////
  // Lock state, encoded as read back from the lock-and-key register
  typedef enum logic [1:0] {
    LOCK_IDLE  = 2'b00,  // Locked, waiting for first key
    LOCK_FIRST = 2'b01,  // First key seen
    LOCK_OPEN  = 2'b10,  // One write or erase allowed
    LOCK_DEAD  = 2'b11   // Locked until reset
  } lock_state_type;

  localparam lock_state_type LOCK_RESET = LOCK_IDLE;  // State after reset

endpackage

// ===== logic/lock_key_fsm.sv
// Lock-and-key state machine that gates flash writes and erases
`timescale 1ns/1ps
module lock_key_fsm
  import flash_guard_pkg::*;
(
  input  wire logic           core_clk,    // System clock
  input  wire logic           nrst,        // Synchronous reset, active low
  input  wire logic           ce,          // Clock enable, freezes state
  input  wire logic           key_write,   // Core writes the key register
  input  wire logic [7:0]     key_value,   // Value written
  input  wire logic           op_start,    // Legal flash operation issued
  input  wire logic           op_illegal,  // Operation tried while closed
  input  wire logic           op_done,     // Flash reports completion
  output lock_state_type      lock_state,  // Current lock state
  output logic                busy         // Operation outstanding
);

  ////////////////////////////////////////////////////////////////////////////
  // All state in one record
  typedef struct packed {
    lock_state_type state;  // Lock state
    logic           busy;   // Operation in flight
  } fsm_type;

  fsm_type st_q;  // Registered state
  fsm_type st_d;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; later assignments take priority
  always_comb begin
    st_d = st_q;
    // Key sequence
    if (key_write) begin
      unique case (st_q.state)
        LOCK_IDLE:  st_d.state = (key_value == KEY_FIRST) ? LOCK_FIRST : LOCK_DEAD;
        LOCK_FIRST: st_d.state = (key_value == KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
        LOCK_OPEN:  st_d.state = LOCK_DEAD;  // A third key write is misuse
        LOCK_DEAD:  st_d.state = LOCK_DEAD;  // Sticky until reset
      endcase
    end
    // Mark the single permitted operation as running
    if (op_start) begin
      st_d.busy = 1'b1;
    end
    // Relock once that operation finishes
    if (op_done && st_q.busy) begin
      st_d.busy = 1'b0;
      if (st_d.state == LOCK_OPEN) begin
        st_d.state = LOCK_IDLE;
      end
    end
    // Misuse overrides every other lock-state update
    if (op_illegal) begin
      st_d.state = LOCK_DEAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= '{state: LOCK_RESET, busy: 1'b0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign lock_state = st_q.state;
  assign busy       = st_q.busy;

endmodule

// ===== logic/flash_program_write_erase_guard.sv
// Flash program write and page erase guard with its two control registers
`timescale 1ns/1ps
module flash_program_write_erase_guard
  import flash_guard_pkg::*;
#(
  parameter int ADDR_W    = 16,  // Store address width
  parameter int PAGE_BITS = 9    // Low address bits inside one flash page
) (
  input  wire logic              core_clk,           // System clock, 250 MHz
  input  wire logic              nrst,               // Synchronous reset, active low
  input  wire logic              ce,                 // Clock enable
  input  wire logic [7:0]        sfr_addr,           // Register address
  input  wire logic              sfr_write,          // Register write strobe
  input  wire logic              sfr_read,           // Register read strobe
  input  wire logic [7:0]        sfr_wdata,          // Register write data
  output logic      [7:0]        sfr_rdata,          // Register read data
  input  wire logic              store_valid,        // External-data store instruction
  input  wire logic [ADDR_W-1:0] store_addr,         // Store address
  input  wire logic [7:0]        store_data,         // Store data
  input  wire logic              flash_done,         // Flash operation complete
  input  wire logic              supply_monitor_on,  // Supply monitor enabled
  input  wire logic              supply_reset_on,    // Monitor enabled as reset source
  output logic                   flash_write_req,    // Program one byte, pulse
  output logic                   flash_erase_req,    // Erase one page, pulse
  output logic      [ADDR_W-1:0] flash_addr,         // Flash address
  output logic      [7:0]        flash_data,         // Byte to program
  output logic                   xram_write_req,     // Ordinary data store, pulse
  output logic      [ADDR_W-1:0] xram_addr,          // Data memory address
  output logic      [7:0]        xram_data,          // Data memory byte
  output logic                   flash_error_reset   // Request device reset, pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // All registered state of this module
  typedef struct packed {
    logic [1:0]        control;  // Erase enable and write enable
    logic [7:0]        rdata;    // Read data
    logic              fwr;      // Flash write pulse
    logic              fer;      // Flash erase pulse
    logic [ADDR_W-1:0] faddr;    // Flash address
    logic [7:0]        fdata;    // Flash data
    logic              xwr;      // Data memory write pulse
    logic [ADDR_W-1:0] xaddr;    // Data memory address
    logic [7:0]        xdata;    // Data memory data
    logic              ferr;     // Flash error reset pulse
  } guard_type;

  guard_type      st_q;        // Registered state
  guard_type      st_d;        // Next state
  lock_state_type lock_state;  // From the key machine
  logic           busy;        // Flash operation outstanding
  logic           key_write;   // Write to lock-and-key register
  logic           we;          // Program write enable
  logic           ee;          // Page erase enable
  logic           supply_ok;   // Both supply guards on
  logic           op_start;    // Legal operation this cycle
  logic           op_illegal;  // Attempt while closed

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the current request
  // Key writes decode here so the machine sees one clean strobe
  assign key_write  = sfr_write && (sfr_addr == FLASH_LOCK_KEY_ADDR);
  assign we         = st_q.control[WRITE_ENABLE_BIT];
  assign ee         = st_q.control[ERASE_ENABLE_BIT];
  assign supply_ok  = supply_monitor_on && supply_reset_on;
  // Only one operation per unlock; a second while busy counts as misuse
  assign op_start   = store_valid && we && supply_ok && (lock_state == LOCK_OPEN) && !busy;
  // A supply fault takes the reset path, not the lock path
  assign op_illegal = store_valid && we && supply_ok && !((lock_state == LOCK_OPEN) && !busy);

  ////////////////////////////////////////////////////////////////////////////
  // Key sequence and relock machine
  lock_key_fsm u_lock (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .ce         (ce),
    .key_write  (key_write),
    .key_value  (sfr_wdata),
    .op_start   (op_start),
    .op_illegal (op_illegal),
    .op_done    (flash_done),
    .lock_state (lock_state),
    .busy       (busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers and store steering
  always_comb begin
    st_d      = st_q;
    // Pulses last one cycle
    st_d.fwr  = 1'b0;
    st_d.fer  = 1'b0;
    st_d.xwr  = 1'b0;
    st_d.ferr = 1'b0;
    // Control register write; upper bits are dropped
    if (sfr_write && (sfr_addr == PROGRAM_STORE_CONTROL_ADDR)) begin
      st_d.control = sfr_wdata[1:0];
    end
    // A read and a write in one cycle both act; the read shows old state
    // Register read; unmapped addresses answer zero
    if (sfr_read) begin
      if (sfr_addr == PROGRAM_STORE_CONTROL_ADDR) begin
        st_d.rdata = {UPPER_ZERO, st_q.control};
      end else if (sfr_addr == FLASH_LOCK_KEY_ADDR) begin
        st_d.rdata = {UPPER_ZERO, lock_state};
      end else begin
        st_d.rdata = RDATA_RESET;
      end
    end
    // Store steering
    // Priority: write enable, then supply guard, then the lock verdict
    if (store_valid) begin
      if (!we) begin
        // Ordinary store, flash untouched
        st_d.xwr   = 1'b1;
        st_d.xaddr = store_addr;
        st_d.xdata = store_data;
      end else if (!supply_ok) begin
        // Unsafe supply: reset the device rather than touch flash
        st_d.ferr = 1'b1;
      end else if (op_start) begin
        if (ee) begin
          // Page erase; data byte is irrelevant
          st_d.fer   = 1'b1;
          st_d.faddr = {store_addr[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
        end else begin
          // Single byte program; software erases first
          st_d.fwr   = 1'b1;
          st_d.faddr = store_addr;
          st_d.fdata = store_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  // Reset wins over ce so a frozen block still comes out clean
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= '{control: CONTROL_RESET, rdata: RDATA_RESET, default: '0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  // No logic between these registers and the pins, so timing stays simple
  assign sfr_rdata         = st_q.rdata;
  assign flash_write_req   = st_q.fwr;
  assign flash_erase_req   = st_q.fer;
  assign flash_addr        = st_q.faddr;
  assign flash_data        = st_q.fdata;
  assign xram_write_req    = st_q.xwr;
  assign xram_addr         = st_q.xaddr;
  assign xram_data         = st_q.xdata;
  assign flash_error_reset = st_q.ferr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Disabled in reset; antecedents gate on ce where state moves
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Upper control bits never read back
  psc_upper_zero_a: assert property (
    ce && sfr_read && (sfr_addr == PROGRAM_STORE_CONTROL_ADDR) |=> sfr_rdata[7:2] == UPPER_ZERO)
    else $error("control upper bits not zero");

  // Control write lands in the two enable bits
  control_write_a: assert property (
    ce && sfr_write && (sfr_addr == PROGRAM_STORE_CONTROL_ADDR)
    |=> (we == $past(sfr_wdata[WRITE_ENABLE_BIT])) && (ee == $past(sfr_wdata[ERASE_ENABLE_BIT])))
    else $error("control write did not land");

  // Erase request carries page-aligned address
  erase_issue_a: assert property (
    ce && op_start && ee |=> flash_erase_req && !flash_write_req && (flash_addr[PAGE_BITS-1:0] == '0))
    else $error("page erase not issued");

  // Erase keeps the page of the store address
  erase_page_a: assert property (
    ce && op_start && ee |=> flash_addr[ADDR_W-1:PAGE_BITS] == $past(store_addr[ADDR_W-1:PAGE_BITS]))
    else $error("erase page address wrong");

  // Byte program carries the stored byte
  write_issue_a: assert property (
    ce && op_start && !ee |=> flash_write_req && !flash_erase_req && (flash_data == $past(store_data)))
    else $error("byte program not issued");

  // Byte program goes to the store address
  write_addr_a: assert property (
    ce && op_start && !ee |=> flash_addr == $past(store_addr))
    else $error("program address wrong");

  // Flash-bound stores never reach data memory
  ram_quiet_a: assert property (
    ce && store_valid && we |=> !xram_write_req)
    else $error("flash store leaked to data memory");

  // Disabled writes never touch flash
  flash_blocked_a: assert property (
    ce && store_valid && !we |=> !flash_write_req && !flash_erase_req && xram_write_req)
    else $error("flash touched with write enable clear");

  // Data memory gets the store address and byte
  xram_copy_a: assert property (
    ce && store_valid && !we |=> (xram_addr == $past(store_addr)) && (xram_data == $past(store_data)))
    else $error("data store carried wrong values");

  // First key moves idle to first-key state
  key_first_a: assert property (
    ce && key_write && (lock_state == LOCK_IDLE) && (sfr_wdata == KEY_FIRST) && !op_illegal
    |=> lock_state == LOCK_FIRST)
    else $error("first key not taken");

  // Second key after the first opens
  key_unlock_a: assert property (
    ce && key_write && (lock_state == LOCK_FIRST) && (sfr_wdata == KEY_SECOND) && !op_illegal
    |=> lock_state == LOCK_OPEN)
    else $error("key sequence did not unlock");

  // Open is reached only through the second key
  open_by_key_a: assert property (
    (lock_state == LOCK_OPEN) && ($past(lock_state) != LOCK_OPEN)
    |-> ($past(lock_state) == LOCK_FIRST) && $past(key_write) && $past(ce))
    else $error("lock opened without key");

  // Completion relocks
  relock_a: assert property (
    ce && busy && flash_done && (lock_state == LOCK_OPEN) && !key_write && !op_illegal
    |=> (lock_state == LOCK_IDLE) && !busy)
    else $error("no relock after completion");

  // One request per unlock; no back-to-back pulse
  pulse_once_a: assert property (
    ce && (flash_write_req || flash_erase_req) |=> !flash_write_req && !flash_erase_req)
    else $error("flash request repeated");

  // Misuse locks and stays locked
  misuse_lock_a: assert property (
    ce && op_illegal |=> (lock_state == LOCK_DEAD) [*4])
    else $error("attempt while closed did not lock");

  // Dead state holds until reset
  dead_sticky_a: assert property (
    lock_state == LOCK_DEAD |=> lock_state == LOCK_DEAD)
    else $error("dead lock state left");

  // Closed flash ignores stores
  closed_quiet_a: assert property (
    ce && store_valid && we && (lock_state != LOCK_OPEN) |=> !flash_write_req && !flash_erase_req)
    else $error("closed flash accepted a store");

  // Wrong first key locks deliberately
  wrong_key_a: assert property (
    ce && key_write && (lock_state == LOCK_IDLE) && (sfr_wdata != KEY_FIRST) |=> lock_state == LOCK_DEAD)
    else $error("wrong first key did not lock");

  // Key register reads the lock state
  key_read_a: assert property (
    ce && sfr_read && (sfr_addr == FLASH_LOCK_KEY_ADDR) |=> sfr_rdata == {UPPER_ZERO, $past(lock_state)})
    else $error("lock state read back wrong");

  // Read data stands until the next read
  rdata_hold_a: assert property (
    ce && !sfr_read |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  // Supply fault resets instead of writing
  supply_fault_a: assert property (
    ce && store_valid && we && !supply_ok
    |=> flash_error_reset && !flash_write_req && !flash_erase_req && !xram_write_req)
    else $error("supply fault not handled");

  // Supply fault leaves the lock state alone
  supply_lock_a: assert property (
    ce && store_valid && we && !supply_ok && !key_write && !flash_done
    |=> lock_state == $past(lock_state))
    else $error("supply fault changed lock state");

  // Ordinary stores leave the lock alone
  xram_lock_a: assert property (
    ce && store_valid && !we && !key_write && !flash_done |=> lock_state == $past(lock_state))
    else $error("data store changed lock state");

  erase_seen_c:   cover property (ce && op_start && ee);
  write_seen_c:   cover property (ce && op_start && !ee);
  dead_seen_c:    cover property (ce && op_illegal);
  supply_seen_c:  cover property (flash_error_reset);
  relock_seen_c:  cover property (ce && busy && flash_done);

endmodule

// ===== verification/core_model.sv
// Core and flash array model that drives the guard's register and store side
`timescale 1ns/1ps
module core_model
  import flash_guard_pkg::*;
(
  input  wire logic        core_clk,         // System clock
  output logic      [7:0]  sfr_addr,         // Register address
  output logic             sfr_write,        // Register write strobe
  output logic             sfr_read,         // Register read strobe
  output logic      [7:0]  sfr_wdata,        // Register write data
  output logic             store_valid,      // Data store strobe
  output logic      [15:0] store_addr,       // Store address
  output logic      [7:0]  store_data,       // Store byte
  input  wire logic        flash_write_req,  // Program request
  input  wire logic        flash_erase_req,  // Erase request
  output logic             flash_done        // Completion pulse
);
  int lat = 1;  // Flash busy time, set per scenario
  int cnt = 0;  // Cycles left of the running operation

  initial begin
    {sfr_addr, sfr_write, sfr_read, sfr_wdata} = '0;
    {store_valid, store_addr, store_data, flash_done} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash side: answers each request after lat cycles
  always @(posedge core_clk) begin
    flash_done <= !(flash_write_req || flash_erase_req) && (cnt == 1);
    if (flash_write_req || flash_erase_req) cnt <= lat;
    else if (cnt > 0) cnt <= cnt - 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core accesses; released data is inverted so stale values never match
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge core_clk);
    sfr_write <= 1'b0;
    sfr_wdata <= ~d;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    @(posedge core_clk);
    sfr_read <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    store_addr  <= a;
    store_data  <= d;
    store_valid <= 1'b1;
    @(posedge core_clk);
    store_valid <= 1'b0;
    store_data  <= ~d;
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking testbench for the flash write and erase guard
`timescale 1ns/1ps
module tb;
  import flash_guard_pkg::*;
  logic           core_clk, nrst, ce, sup_m, sup_r;  // Clock, reset, levels
  logic [7:0]     sfr_addr, sfr_wdata, sfr_rdata, store_data, fd, xd;
  logic           sfr_write, sfr_read, store_valid, flash_done;
  logic           fw, fe, xw, er;                    // Request pulses
  logic [15:0]    store_addr, flash_addr, xram_addr, fa, xa, pg;
  logic [1:0]     ctl;                               // Expected control bits
  lock_state_type exp_lock;                          // Expected lock state
  int error_cnt, samples_checked, cnt_w, cnt_e, cnt_x, cnt_r;

  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end

  core_model u_core (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_wdata(sfr_wdata), .store_valid(store_valid), .store_addr(store_addr), .store_data(store_data),
    .flash_write_req(fw), .flash_erase_req(fe), .flash_done(flash_done));

  flash_program_write_erase_guard #(.ADDR_W(16), .PAGE_BITS(9)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .ce(ce), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .store_valid(store_valid), .store_addr(store_addr), .store_data(store_data),
    .flash_done(flash_done), .supply_monitor_on(sup_m), .supply_reset_on(sup_r), .flash_write_req(fw),
    .flash_erase_req(fe), .flash_addr(flash_addr), .flash_data(fd), .xram_write_req(xw),
    .xram_addr(xram_addr), .xram_data(xd), .flash_error_reset(er));

  ////////////////////////////////////////////////////////////////////////////
  // Pulse monitor: counts requests and keeps the address each flash or data memory request carried
  always @(posedge core_clk) if (nrst === 1'b1) begin
    if (fw === 1'b1) cnt_w++;
    if (fe === 1'b1) cnt_e++;
    if (fw === 1'b1 || fe === 1'b1) fa = flash_addr;
    if (xw === 1'b1) begin
      cnt_x++;
      xa = xram_addr;
    end
    if (er === 1'b1) cnt_r++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation, comparison and access helpers
  function automatic lock_state_type key_next(lock_state_type s, logic [7:0] v);
    if (s == LOCK_IDLE) return (v === KEY_FIRST) ? LOCK_FIRST : LOCK_DEAD;
    if (s == LOCK_FIRST) return (v === KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
    return LOCK_DEAD;  // Open also dies on any key write
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_core.reg_rd(a);
    chk("rdata", {8'h00, e}, {8'h00, sfr_rdata});
  endtask

  task automatic kw(input logic [7:0] v);
    u_core.reg_wr(FLASH_LOCK_KEY_ADDR, v);
    exp_lock = key_next(exp_lock, v);
  endtask

  task automatic cw(input logic [7:0] v);
    u_core.reg_wr(PROGRAM_STORE_CONTROL_ADDR, v);
    ctl = v[1:0];
  endtask

  task automatic st(input logic [15:0] a, input logic [7:0] d);
    int w, e, x, r;
    w = cnt_w;
    e = cnt_e;
    x = cnt_x;
    r = cnt_r;
    u_core.store(a, d);
    repeat (u_core.lat + 4) @(posedge core_clk);
    #1;
    if (!ctl[0]) begin
      x++;
      chk("xram_addr", a, xa);
      chk("xram_data", {8'h00, d}, {8'h00, xd});
    end else if (!(sup_m && sup_r)) r++;
    else if (exp_lock == LOCK_OPEN) begin
      if (ctl[1]) begin
        e++;
        chk("page_addr", a & 16'hFE00, fa);
      end else begin
        w++;
        chk("flash_data", {8'h00, d}, {8'h00, fd});
        chk("flash_addr", a, fa);
      end
      exp_lock = LOCK_IDLE;  // Relock after completion
    end else exp_lock = LOCK_DEAD;  // Closed attempt
    chk("writes", 16'(w), 16'(cnt_w));
    chk("erases", 16'(e), 16'(cnt_e));
    chk("xram", 16'(x), 16'(cnt_x));
    chk("err_reset", 16'(r), 16'(cnt_r));
    rd(FLASH_LOCK_KEY_ADDR, {6'h00, exp_lock});
  endtask

  task automatic rst;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst     <= 1'b1;
    ctl      = 2'h0;
    exp_lock = LOCK_IDLE;
    @(posedge core_clk);
  endtask

  task automatic test_done;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: directed corners first, then random sequences
  initial begin
    nrst = 1'b0;
    ce   = 1'b1;  // Clock enable on; one frozen key write below
    sup_m = 1'b1;
    sup_r = 1'b1;
    void'($urandom(32'h9a75));
    rst();
    rd(PROGRAM_STORE_CONTROL_ADDR, 8'h00);
    rd(FLASH_LOCK_KEY_ADDR, 8'h00);
    rd(8'h90, 8'h00);  // Unmapped address reads zero
    // Frozen clock enable must swallow a locking key write
    ce <= 1'b0;
    u_core.reg_wr(FLASH_LOCK_KEY_ADDR, 8'h5A);
    ce <= 1'b1;
    rd(FLASH_LOCK_KEY_ADDR, 8'h00);
    cw(8'hFF);
    rd(PROGRAM_STORE_CONTROL_ADDR, 8'h03);
    cw(8'h00);
    st(16'($urandom), 8'($urandom));
    kw(KEY_FIRST);
    rd(FLASH_LOCK_KEY_ADDR, 8'h01);
    kw(KEY_SECOND);
    rd(FLASH_LOCK_KEY_ADDR, 8'h02);
    cw(8'h03);
    pg = 16'($urandom);
    st(pg, 8'($urandom));
    kw(KEY_FIRST);
    kw(KEY_SECOND);
    cw(8'h01);
    u_core.lat = 20;
    st({pg[15:9], 9'($urandom)}, 8'($urandom));
    u_core.lat = 1;
    kw(KEY_FIRST);
    kw(KEY_SECOND);
    sup_m <= 1'b0;
    st(16'($urandom), 8'($urandom));
    sup_m <= 1'b1;
    st(16'($urandom), 8'($urandom));
    // Closed attempt, then a late key sequence that must not revive it
    st(16'($urandom), 8'($urandom));
    kw(KEY_FIRST);
    kw(KEY_SECOND);
    st(16'($urandom), 8'($urandom));
    rst();
    kw(8'h5A);
    rd(FLASH_LOCK_KEY_ADDR, 8'h03);
    repeat (40) begin
      rst();
      repeat ($urandom % 4) kw(($urandom % 3 == 0) ? 8'($urandom) : (exp_lock == LOCK_IDLE ? KEY_FIRST : KEY_SECOND));
      cw(8'($urandom));
      sup_r <= ($urandom % 4 != 0);
      @(posedge core_clk);
      st(16'($urandom), 8'($urandom));
      sup_r <= 1'b1;
    end
    test_done();
  end
endmodule
